// [hdl/drm_top.v]
// Operation
// - double rate mode runs the internal sample tick at twice the base rate
// - sample words stay 24 bits wide in both speeds
// - double rate channel n travels on link channels 2n-1 and 2n, a then b
// - link frames keep the single speed rate while multiplexing
// - in double rate one serial wire carries one channel, odd sample left, even right
// - status byte 0 bit 0 picks professional or consumer field layout
// - decode audio flag, emphasis, copy, locked, frequency and mode fields
// - report path offset of 4 samples single speed, 8 double speed
// - report a fixed safety offset of 32 samples
// - pass-through from receiver to transmitter delays 4 or 8 samples
`timescale 1ns/100ps
`default_nettype none
`include "drm_regs.vh"

module drm_top #(
   parameter SW    = 24,
   parameter NCH   = 8,
   parameter FDEP  = 8,
   parameter FAW   = 3
) (
   input  wire              clk_i,
   input  wire              rst_i,
   // register bus
   input  wire [7:0]        wb_adr_i,
   input  wire [31:0]       wb_dat_i,
   input  wire [3:0]        wb_sel_i,
   input  wire              wb_we_i,
   input  wire              wb_cyc_i,
   input  wire              wb_stb_i,
   output reg  [31:0]       wb_dat_o,
   output reg               wb_ack_o,
   // host playback stream
   input  wire [SW-1:0]     tx_data_i,
   input  wire              tx_valid_i,
   output wire              tx_ready_o,
   // host record stream
   output reg  [SW-1:0]     rx_data_o,
   output reg  [2:0]        rx_chan_o,
   output reg               rx_valid_o,
   input  wire              rx_ready_i,
   // optical link, eight channels flattened
   output reg  [NCH*SW-1:0] link_tx_data_o,
   output reg               link_tx_frame_o,
   input  wire [NCH*SW-1:0] link_rx_data_i,
   input  wire              link_rx_frame_i,
   // serial two-channel wire
   output reg  [SW-1:0]     ser_tx_left_o,
   output reg  [SW-1:0]     ser_tx_right_o,
   output reg               ser_tx_frame_o,
   input  wire [SW-1:0]     ser_rx_left_i,
   input  wire [SW-1:0]     ser_rx_right_i,
   input  wire              ser_rx_frame_i,
   input  wire [7:0]        cs_byte_i,
   // internal sample rate enable
   output reg               sample_tick_o
);

   // link slot of a word: plain order, or pair-interleaved in double rate
   function [2:0] slot_of;
      input       dbl;
      input [2:0] idx;
      begin
         if (dbl)
            slot_of = {idx[1:0], idx[2]};
         else
            slot_of = idx;
      end
   endfunction

   integer i_ld, i_dly, i_tx, i_rx;

   // ---------------- registers ----------------
   reg  [3:0]  ctrl;
   reg  [11:0] status;
   wire        double_rate_mode       = ctrl[`DRM_CTRL_DBL];
   wire        sample_interleave_mode = double_rate_mode;
   wire        base_48k               = ctrl[`DRM_CTRL_48K];
   wire        thru_en                = ctrl[`DRM_CTRL_THRU];
   wire        run                    = ctrl[`DRM_CTRL_RUN];
   wire        wb_req                 = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   wire [17:0] base_hz   = base_48k ? `DRM_RATE_48 : `DRM_RATE_441;
   wire [17:0] rate_hz   = double_rate_mode ? {base_hz[16:0], 1'b0} : base_hz;
   wire [7:0]  path_ofs  = double_rate_mode ? `DRM_OFS_DOUBLE
                                            : `DRM_OFS_SINGLE;

   reg  [31:0] rd_word;

   always @* begin
      rd_word = 32'h0000_0000;
      case (wb_adr_i)
         `DRM_ADR_CTRL: rd_word = {28'h000_0000, ctrl};
         `DRM_ADR_STAT: rd_word = {20'h0_0000, status};
         `DRM_ADR_LAT:  rd_word = {16'h0000, `DRM_OFS_SAFETY, path_ofs};
         `DRM_ADR_RATE: rd_word = {14'h0000, rate_hz};
         default:       rd_word = 32'h0000_0000;
      endcase
   end

   // single-cycle answer; unmapped offsets ack and read zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl     <= `DRM_CTRL_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req)
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_word;
         // commit on the edge where the master sees ack, request still held
         if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
             && wb_adr_i == `DRM_ADR_CTRL)
            ctrl <= wb_dat_i[3:0];
      end
   end

   // ---------------- sample rate generation ----------------
   // phase accumulator: one enable per sample, jitter below one clock
   localparam [63:0] INC_48_W  = `DRM_INC_48;
   localparam [63:0] INC_441_W = `DRM_INC_441;
   wire [31:0] inc_base = base_48k ? INC_48_W[31:0] : INC_441_W[31:0];
   wire [31:0] inc      = double_rate_mode ? {inc_base[30:0], 1'b0}
                                           : inc_base;
   reg  [31:0] acc;
   reg  [32:0] next_acc;
   reg         phase;
   wire        link_tick = sample_tick_o & ~phase;

   always @* begin
      next_acc = {1'b0, acc} + {1'b0, inc};
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         acc           <= 32'h0000_0000;
         sample_tick_o <= 1'b0;
         phase         <= 1'b0;
      end else begin
         acc           <= run ? next_acc[31:0] : 32'h0000_0000;
         sample_tick_o <= run & next_acc[32];
         if (sample_tick_o)
            phase <= double_rate_mode ? ~phase : 1'b0;
         else if (!double_rate_mode)
            phase <= 1'b0;
      end
   end

   // ---------------- playback path ----------------
   wire [SW-1:0] f_data;
   wire          f_valid;
   reg           ld_busy;
   reg  [2:0]    ld_cnt;
   reg           ld_ph;
   wire          f_ready = ld_busy;
   wire [2:0]    ld_last = double_rate_mode ? 3'h3 : 3'h7;
   reg  [SW-1:0] stage [0:NCH-1];

   drm_fifo #(
      .W     (SW),
      .DEPTH (FDEP),
      .AW    (FAW)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_data_i   (tx_data_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .out_data_o  (f_data),
      .out_valid_o (f_valid),
      .out_ready_i (f_ready)
   );

   // a late host leaves unloaded slots holding old words, and the next tick
   // restarts at slot 0 (slot 1 on a double rate b tick), so its leftover later channels land in earlier slots
   always @(posedge clk_i) begin
      if (rst_i) begin
         ld_busy <= 1'b0;
         ld_cnt  <= 3'h0;
         ld_ph   <= 1'b0;
         for (i_ld = 0; i_ld < NCH; i_ld = i_ld + 1)
            stage[i_ld] <= {SW{1'b0}};
      end else if (sample_tick_o) begin
         ld_busy <= 1'b1;
         ld_cnt  <= 3'h0;
         ld_ph   <= phase;
      end else if (ld_busy && f_valid) begin
         if (double_rate_mode)
            stage[slot_of(1'b1, {ld_ph, ld_cnt[1:0]})] <= f_data;
         else
            stage[ld_cnt] <= f_data;
         ld_cnt <= ld_cnt + 3'h1;
         if (ld_cnt == ld_last)
            ld_busy <= 1'b0;
      end
   end

   // ---------------- pass-through delay line ----------------
   reg  [SW-1:0] srx_l1, srx_l2, srx_r1, srx_r2;
   reg           srx_f1, srx_f2, srx_f3;
   reg  [7:0]    cs1, cs2;
   reg  [2*SW-1:0] dly [0:`DRM_THRU_DEPTH-1];
   wire          srx_rise = srx_f2 & ~srx_f3;

   // one wire frame holds two samples in double rate, so four frames
   // give four samples single speed and eight double speed
   always @(posedge clk_i) begin
      if (rst_i) begin
         srx_l1 <= {SW{1'b0}};
         srx_l2 <= {SW{1'b0}};
         srx_r1 <= {SW{1'b0}};
         srx_r2 <= {SW{1'b0}};
         srx_f1 <= 1'b0;
         srx_f2 <= 1'b0;
         srx_f3 <= 1'b0;
         cs1    <= 8'h00;
         cs2    <= 8'h00;
         for (i_dly = 0; i_dly < `DRM_THRU_DEPTH; i_dly = i_dly + 1)
            dly[i_dly] <= {2*SW{1'b0}};
      end else begin
         srx_l1 <= ser_rx_left_i;
         srx_l2 <= srx_l1;
         srx_r1 <= ser_rx_right_i;
         srx_r2 <= srx_r1;
         srx_f1 <= ser_rx_frame_i;
         srx_f2 <= srx_f1;
         srx_f3 <= srx_f2;
         cs1    <= cs_byte_i;
         cs2    <= cs1;
         if (srx_rise) begin
            dly[0] <= {srx_l2, srx_r2};
            for (i_dly = 1; i_dly < `DRM_THRU_DEPTH; i_dly = i_dly + 1)
               dly[i_dly] <= dly[i_dly-1];
         end
      end
   end

   // ---------------- channel status decode ----------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         status <= `DRM_ST_RST;
      end else begin
         status[`DRM_ST_DBL] <= double_rate_mode;
         if (srx_rise) begin
            status[`DRM_ST_PRO]  <= cs2[`DRM_CS_PRO];
            status[`DRM_ST_NAUD] <= cs2[`DRM_CS_AUDIO];
            if (cs2[`DRM_CS_PRO]) begin
               status[`DRM_ST_EMPH] <= cs2[`DRM_CS_EMPH];
               status[`DRM_ST_COPY] <= 1'b0;
               status[`DRM_ST_LOCK] <= cs2[`DRM_CS_LOCK];
               status[`DRM_ST_FREQ] <= cs2[`DRM_CS_TOP];
               status[`DRM_ST_MODE] <= 2'h0;
            end else begin
               status[`DRM_ST_EMPH] <= {1'b0, cs2[`DRM_CS_CEMPH]};
               status[`DRM_ST_COPY] <= cs2[`DRM_CS_COPY];
               status[`DRM_ST_LOCK] <= 1'b0;
               status[`DRM_ST_FREQ] <= 2'h0;
               status[`DRM_ST_MODE] <= cs2[`DRM_CS_TOP];
            end
         end
      end
   end

   // ---------------- link and wire transmit ----------------
   // frame copied at the start of an a period, so pairs never tear
   always @(posedge clk_i) begin
      if (rst_i) begin
         link_tx_data_o  <= {NCH*SW{1'b0}};
         link_tx_frame_o <= 1'b0;
         ser_tx_left_o   <= {SW{1'b0}};
         ser_tx_right_o  <= {SW{1'b0}};
         ser_tx_frame_o  <= 1'b0;
      end else begin
         link_tx_frame_o <= link_tick;
         ser_tx_frame_o  <= link_tick;
         if (link_tick) begin
            for (i_tx = 0; i_tx < NCH; i_tx = i_tx + 1)
               link_tx_data_o[i_tx*SW +: SW] <= stage[i_tx];
            if (thru_en) begin
               ser_tx_left_o  <= dly[`DRM_THRU_DEPTH-1][2*SW-1:SW];
               ser_tx_right_o <= dly[`DRM_THRU_DEPTH-1][SW-1:0];
            end else begin
               // slots 0/1 are channels 1/2, or samples a/b of channel 1
               ser_tx_left_o  <= stage[0];
               ser_tx_right_o <= stage[1];
            end
         end
      end
   end

   // ---------------- link receive ----------------
   reg  [NCH*SW-1:0] lrx_d1, lrx_d2;
   reg               lrx_f1, lrx_f2, lrx_f3;
   reg  [SW-1:0]     rxbuf [0:NCH-1];
   reg               rx_busy;
   reg  [2:0]        rx_cnt;
   reg               rx_dbl;
   wire              lrx_rise = lrx_f2 & ~lrx_f3;
   wire [2:0]        rx_slot  = slot_of(rx_dbl, rx_cnt);

   always @(posedge clk_i) begin
      if (rst_i) begin
         lrx_d1 <= {NCH*SW{1'b0}};
         lrx_d2 <= {NCH*SW{1'b0}};
         lrx_f1 <= 1'b0;
         lrx_f2 <= 1'b0;
         lrx_f3 <= 1'b0;
      end else begin
         lrx_d1 <= link_rx_data_i;
         lrx_d2 <= lrx_d1;
         lrx_f1 <= link_rx_frame_i;
         lrx_f2 <= lrx_f1;
         lrx_f3 <= lrx_f2;
      end
   end

   // a new frame restarts the walk; a slow host loses the rest
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_busy    <= 1'b0;
         rx_cnt     <= 3'h0;
         rx_dbl     <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_data_o  <= {SW{1'b0}};
         rx_chan_o  <= 3'h0;
         for (i_rx = 0; i_rx < NCH; i_rx = i_rx + 1)
            rxbuf[i_rx] <= {SW{1'b0}};
      end else if (lrx_rise) begin
         for (i_rx = 0; i_rx < NCH; i_rx = i_rx + 1)
            rxbuf[i_rx] <= lrx_d2[i_rx*SW +: SW];
         rx_busy <= 1'b1;
         rx_cnt  <= 3'h0;
         rx_dbl  <= sample_interleave_mode;
         if (rx_ready_i)
            rx_valid_o <= 1'b0;
      end else if (rx_busy && (!rx_valid_o || rx_ready_i)) begin
         rx_data_o  <= rxbuf[rx_slot];
         rx_chan_o  <= rx_dbl ? {1'b0, rx_cnt[1:0]} : rx_cnt;
         rx_valid_o <= 1'b1;
         rx_cnt     <= rx_cnt + 3'h1;
         if (rx_cnt == 3'h7)
            rx_busy <= 1'b0;
      end else if (rx_ready_i) begin
         rx_valid_o <= 1'b0;
      end
   end

endmodule // drm_top

`default_nettype wire

// [hdl/drm_regs.vh]
`ifndef DRM_REGS_VH
`define DRM_REGS_VH

// register byte offsets
`define DRM_ADR_CTRL     8'h00
`define DRM_ADR_STAT     8'h04
`define DRM_ADR_LAT      8'h08
`define DRM_ADR_RATE     8'h0C

// control register fields
`define DRM_CTRL_DBL     0
`define DRM_CTRL_48K     1
`define DRM_CTRL_THRU    2
`define DRM_CTRL_RUN     3
`define DRM_CTRL_RST     4'h0

// status register fields
`define DRM_ST_PRO       0
`define DRM_ST_NAUD      1
`define DRM_ST_EMPH      4:2
`define DRM_ST_COPY      5
`define DRM_ST_LOCK      6
`define DRM_ST_FREQ      8:7
`define DRM_ST_MODE      10:9
`define DRM_ST_DBL       11
`define DRM_ST_RST       12'h000

// channel status byte 0 bit positions
`define DRM_CS_PRO       0
`define DRM_CS_AUDIO     1
`define DRM_CS_EMPH      4:2
`define DRM_CS_CEMPH     4:3
`define DRM_CS_COPY      2
`define DRM_CS_LOCK      5
`define DRM_CS_TOP       7:6

// base rates and clock, in Hz
`define DRM_CLK_HZ       64'h0000_0000_0773_5940
`define DRM_RATE_441     18'h0_AC44
`define DRM_RATE_48      18'h0_BB80
`define DRM_INC_441      ((64'h0000_0000_0000_AC44 << 32) / `DRM_CLK_HZ)
`define DRM_INC_48       ((64'h0000_0000_0000_BB80 << 32) / `DRM_CLK_HZ)

// reported latency figures, in samples
`define DRM_OFS_SINGLE   8'h04
`define DRM_OFS_DOUBLE   8'h08
`define DRM_OFS_SAFETY   8'h20

// pass-through delay line, in wire frames
`define DRM_THRU_DEPTH   4

`endif

// [hdl/drm_fifo.v]
`timescale 1ns/100ps
`default_nettype none

module drm_fifo #(
   parameter W     = 24,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire           clk_i,
   input  wire           rst_i,
   input  wire [W-1:0]   in_data_i,
   input  wire           in_valid_i,
   output reg            in_ready_o,
   output wire [W-1:0]   out_data_o,
   output reg            out_valid_o,
   input  wire           out_ready_i
);
   localparam [AW:0] FULL = DEPTH[AW:0];

   reg  [W-1:0]  mem [0:DEPTH-1];
   reg  [AW-1:0] wr_ptr;
   reg  [AW-1:0] rd_ptr;
   reg  [AW:0]   count;
   reg  [AW:0]   next_count;
   wire          push = in_valid_i & in_ready_o;
   wire          pop  = out_valid_o & out_ready_i;

   assign out_data_o = mem[rd_ptr];

   always @* begin
      next_count = count;
      if (push & ~pop)
         next_count = count + 1'b1;
      else if (pop & ~push)
         next_count = count - 1'b1;
   end

   // flags are registered so both handshakes leave from flops
   always @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr      <= {AW{1'b0}};
         rd_ptr      <= {AW{1'b0}};
         count       <= {(AW+1){1'b0}};
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data_i;
            wr_ptr      <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop)
            rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         count       <= next_count;
         in_ready_o  <= (next_count != FULL);
         out_valid_o <= (next_count != {(AW+1){1'b0}});
      end
   end
endmodule // drm_fifo

`default_nettype wire

// [verification/drm_top_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module drm_chk #(parameter SW = 24) (
   input wire logic          clk_i,
   input wire logic          rst_i,
   input wire logic          wb_cyc_i,
   input wire logic          wb_stb_i,
   input wire logic          wb_ack_o,
   input wire logic          rx_valid_o,
   input wire logic          rx_ready_i,
   input wire logic [SW-1:0] rx_data_o,
   input wire logic [2:0]    rx_chan_o,
   input wire logic          sample_tick_o,
   input wire logic          link_tx_frame_o,
   input wire logic          ser_tx_frame_o
);
   logic [11:0] tcnt;
   logic [11:0] fcnt;
   logic        tseen;
   logic        fseen;
   // saturating gap counters; a stopped tick shows as a count past the bound
   always @(posedge clk_i) begin
      if (rst_i) begin
         tcnt  <= 12'h001;
         fcnt  <= 12'h001;
         tseen <= 1'b0;
         fseen <= 1'b0;
      end else begin
         tcnt  <= sample_tick_o ? 12'h001 : tcnt + {11'h000, ~&tcnt};
         fcnt  <= link_tx_frame_o ? 12'h001 : fcnt + {11'h000, ~&fcnt};
         tseen <= tseen | sample_tick_o;
         fseen <= fseen | link_tx_frame_o;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_delay: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("register answer late");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
      else $error("ack without request");
   chk_frame_tick: assert property (link_tx_frame_o |-> $past(sample_tick_o))
      else $error("link frame not after a tick");
   chk_ser_link: assert property (ser_tx_frame_o == link_tx_frame_o)
      else $error("serial frame apart from link frame");
   chk_tick_gap: assert property (sample_tick_o && tseen |-> tcnt >= 12'h515)
      else $error("sample tick too fast");
   chk_tick_alive: assert property (tseen |-> tcnt <= 12'hB14)
      else $error("sample tick too slow");
   chk_frame_gap: assert property (link_tx_frame_o && fseen |-> fcnt >= 12'hA2B)
      else $error("link frame above base rate");
   chk_frame_alive: assert property (fseen |-> fcnt <= 12'hB14)
      else $error("link frame below base rate");
   chk_rx_hold: assert property (rx_valid_o && !rx_ready_i |=>
      rx_valid_o && $stable(rx_data_o) && $stable(rx_chan_o))
      else $error("record word dropped while stalled");
endmodule // drm_chk
bind drm_top drm_chk #(.SW(SW)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .rx_valid_o, .rx_ready_i, .rx_data_o, .rx_chan_o, .sample_tick_o, .link_tx_frame_o,
   .ser_tx_frame_o);
`default_nettype wire

// [verification/drm_far_end.sv]
`timescale 1ns/100ps
`default_nettype none
module drm_far_end #(parameter PER = 2500) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [7:0]   cs_i,
   output var  logic [191:0] link_o,
   output var  logic         frame_o,
   output var  logic [23:0]  left_o,
   output var  logic [23:0]  right_o,
   output var  logic [7:0]   cs_o,
   output var  logic [7:0]   n_o
);
   logic [11:0] cnt;
   integer      k;
   always @(posedge clk_i) begin
      if (rst_i || cnt == PER - 1)
         cnt <= 12'h000;
      else
         cnt <= cnt + 12'h001;
      frame_o <= !rst_i && cnt < 12'h008;
      if (rst_i) begin
         n_o    <= 8'h00;
         link_o <= '0;
      end else if (cnt == 12'h000) begin
         n_o <= n_o + 8'h01;
         for (k = 0; k < 8; k = k + 1)
            link_o[24*k +: 24] <= {n_o + 8'h01, 13'h0000, k[2:0]};
         left_o  <= {n_o + 8'h01, 16'h000A};
         right_o <= {n_o + 8'h01, 16'h000B};
         cs_o    <= cs_i;
      end else if (cnt == 12'h03C) begin
         // hold time over: inverse, so stale capture cannot match
         link_o  <= ~link_o;
         left_o  <= ~left_o;
         right_o <= ~right_o;
         cs_o    <= ~cs_o;
      end
   end
endmodule // drm_far_end
`default_nettype wire

// [verification/drm_top_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "drm_regs.vh"
module drm_top_test;
   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic [7:0]   wb_adr_i = 8'h00;
   logic [31:0]  wb_dat_i = 32'h0000_0000;
   logic         wb_we_i = 1'b0;
   logic         wb_cyc_i = 1'b0;
   logic         wb_stb_i = 1'b0;
   logic [23:0]  tx_data_i = 24'h00_0000;
   logic         tx_valid_i = 1'b0;
   logic         rx_ready_i = 1'b1;
   logic [7:0]   cs = 8'hA5;
   logic [31:0]  rate [4] = '{32'h0000_AC44, 32'h0001_5888, 32'h0000_BB80, 32'h0001_7700};
   wire  [31:0]  wb_dat_o;
   wire          wb_ack_o, tx_ready_o, rx_valid_o, link_tx_frame_o, ser_tx_frame_o;
   wire          sample_tick_o, frm;
   wire  [23:0]  rx_data_o, ser_tx_left_o, ser_tx_right_o, sl, sr;
   wire  [2:0]   rx_chan_o;
   wire  [191:0] link_tx_data_o, lrx;
   wire  [7:0]   csb, n;
   integer       num_errors = 0;
   integer       checks_done = 0;
   integer       m, k;
   always #4 clk_i = ~clk_i;
   drm_top DUT (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF), .wb_we_i, .wb_cyc_i,
      .wb_stb_i, .wb_dat_o, .wb_ack_o, .tx_data_i, .tx_valid_i, .tx_ready_o, .rx_data_o,
      .rx_chan_o, .rx_valid_o, .rx_ready_i, .link_tx_data_o, .link_tx_frame_o,
      .link_rx_data_i(lrx), .link_rx_frame_i(frm), .ser_tx_left_o, .ser_tx_right_o,
      .ser_tx_frame_o, .ser_rx_left_i(sl), .ser_rx_right_i(sr), .ser_rx_frame_i(frm),
      .cs_byte_i(csb), .sample_tick_o);
   drm_far_end far (.clk_i, .rst_i, .cs_i(cs), .link_o(lrx), .frame_o(frm), .left_o(sl),
      .right_o(sr), .cs_o(csb), .n_o(n));
   task finish_test;
      begin
         $display("errors %0d checks %0d", num_errors, checks_done);
         if (num_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task ck(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   // bounded wait, returns at the falling edge where the event is seen
   task wt(input integer w);
      integer i;
      logic   s;
      begin
         s = 1'b0;
         for (i = 0; i < 6000 && s !== 1'b1; i = i + 1) begin
            @(negedge clk_i);
            case (w)
               0: s = link_tx_frame_o;
               1: s = sample_tick_o;
               2: s = rx_valid_o;
               3: s = far.cnt == 12'h001;
               4: s = tx_ready_o;
               default: s = wb_ack_o;
            endcase
         end
         if (s !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("BAD %0t wait timed out", $time);
            finish_test;
         end
      end
   endtask
   task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
      integer i;
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i  <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         // ack and read data are taken on a rising edge only
         i = 0;
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1 && i < 1000) begin
            @(posedge clk_i);
            i = i + 1;
         end
         if (wb_ack_o !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("BAD %0t bus answer timed out", $time);
            finish_test;
         end
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      logic [31:0] q;
      begin
         wb(1'b0, a, 32'h0000_0000, q);
         ck(q, e);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      logic [31:0] q;
      begin
         wb(1'b1, a, d, q);
      end
   endtask
   task load(input [23:0] b);
      integer i;
      begin
         @(posedge clk_i);
         for (i = 0; i < 8; i = i + 1) begin
            tx_data_i  <= b + i;
            tx_valid_i <= 1'b1;
            wt(4);
            @(posedge clk_i);
         end
         tx_valid_i <= 1'b0;
      end
   endtask
   task getword(input [23:0] e, input [2:0] c);
      begin
         wt(2);
         @(posedge clk_i);
         @(posedge clk_i);
         rx_ready_i <= 1'b1;
         @(negedge clk_i);
         ck(rx_data_o, e);
         ck(rx_chan_o, c);
         @(posedge clk_i);
         rx_ready_i <= 1'b0;
      end
   endtask
   task rec(input d);
      integer     i;
      logic [7:0] f;
      logic [2:0] s;
      begin
         wt(3);
         f = n;
         @(posedge clk_i);
         rx_ready_i <= 1'b0;
         for (i = 0; i < 8; i = i + 1) begin
            s = d ? (i < 4 ? 2 * i : 2 * i - 7) : i;
            getword({f, 13'h0000, s}, d ? i % 4 : i);
         end
         @(posedge clk_i);
         rx_ready_i <= 1'b1;
      end
   endtask
   task rs;
      begin
         rst_i <= 1'b1;
         repeat (2) @(posedge clk_i);
         rst_i <= 1'b0;
      end
   endtask
   initial begin
      rs;
      rd(`DRM_ADR_CTRL, 32'h0000_0000);
      for (m = 0; m < 4; m = m + 1) begin
         wr(`DRM_ADR_CTRL, m);
         rd(`DRM_ADR_CTRL, m);
         rd(`DRM_ADR_RATE, rate[m]);
         rd(`DRM_ADR_LAT, m % 2 ? 32'h0000_2008 : 32'h0000_2004);
      end
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, 32'h0000_0000);
      wt(3);
      wt(3);
      rd(`DRM_ADR_STAT, 32'h0000_0945);
      cs <= 8'h4E;
      wt(3);
      wt(3);
      rd(`DRM_ADR_STAT, 32'h0000_0A26);
      // loaded while stopped so the fifo fills; in double rate the first
      // tick is an a period: words 0..3 go to a slots, 4..7 to b slots
      for (m = 0; m < 2; m = m + 1) begin
         rs;
         load(24'h50_0000);
         @(negedge clk_i);
         ck(tx_ready_o, 0);
         wr(`DRM_ADR_CTRL, 32'h0000_0008 + m);
         wt(0);
         wt(0);
         for (k = 0; k < 8; k = k + 1)
            ck(link_tx_data_o[24*k +: 24],
               24'h50_0000 + (m ? (k % 2 ? 4 + k / 2 : k / 2) : k));
         ck(ser_tx_left_o, 24'h50_0000);
         ck(ser_tx_right_o, m ? 24'h50_0004 : 24'h50_0001);
         ck(tx_ready_o, 1);
         rec(m);
      end
      rs;
      wr(`DRM_ADR_CTRL, 32'h0000_000C);
      repeat (6) wt(3);
      wt(0);
      // newest frame sits in the first stage, so the word out is three frames older
      ck(ser_tx_left_o, {n - 8'h03, 16'h000A});
      ck(ser_tx_right_o, {n - 8'h03, 16'h000B});
      finish_test;
   end
endmodule // drm_top_test
`default_nettype wire
